// ### hdl/tacc_timer.sv
// aux 16-bit timer with compare, reload and three edge-capture channels, AHB-Lite slave
// assumes capture pins are synchronous to clk and single whole-word bus transfers
//
// Overview of operation
// - set overflow/match flag when the counter rolls over past its maximum.
// - in compare mode, set the flag when counter equals the reload/compare value.
// - hardware never clears the flag; only a software write clears it.
// - software writing one to the flag sets it like a hardware event.
// - reload enable permits loading the counter from the reload/compare value.
// - enabled qualifying edge on pin two copies counter into capture set two.
// - enabled qualifying edge on pin one copies counter into capture set one.
// - enabled qualifying edge on pin zero copies counter into capture set zero.
// - each channel detects only the edge chosen by its own two-bit select.
// - capture edge also reloads counter when reload enable is one, select zero.
// - capture mode with capture auto-clear zeroes the counter after a capture; if reload enable is also one, the counter reloads instead.
// - compare auto-clear one zeroes the counter on match; zero keeps counting.
// - reload/compare value is reload value or match value per the select bit.
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/1ps
`include "tacc_cfg.svh"

module tacc_timer #(
	parameter int COUNT_WIDTH = 16,
	parameter int CHANNELS = 3
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic capture_pin_zero,
	input wire logic capture_pin_one,
	input wire logic capture_pin_two,
	output logic irq
);

	// true when the edge between two samples matches the select code
	function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
		logic rise;
		logic fall;
		rise = ~prev & cur;
		fall = prev & ~cur;
		case (sel)
			`TACC_EDGE_FALL: edge_hit = fall;
			`TACC_EDGE_RISE: edge_hit = rise;
			`TACC_EDGE_BOTH: edge_hit = rise | fall;
			default: edge_hit = 1'b0;
		endcase
	endfunction

	// word index of a byte address; upper bits outside the map give an unused index
	function automatic logic [7:0] reg_index(input logic [31:0] addr);
		if (addr[31:10] != 22'h00_0000) begin
			reg_index = 8'hff;
		end else begin
			reg_index = addr[9:2];
		end
	endfunction

	// a register access lands in the data phase, at the index latched in the address phase
	function automatic logic reg_hit(input logic strobe, input logic [7:0] idx,
			input logic [7:0] want);
		reg_hit = strobe & (idx == want);
	endfunction

	// reset images of the two control registers; only the stored fields are taken from them
	localparam logic [7:0] CTL_RESET = `TACC_CTL_RESET;
	localparam logic [7:0] MOD_RESET = `TACC_MOD_RESET;

	// bus state
	tacc_pkg::tacc_bus_e bus_q;
	tacc_pkg::tacc_bus_e bus_d;
	logic [7:0] idx_q;
	logic addr_take;
	logic wr_cycle;
	logic rd_cycle;

	// software-visible state
	logic flag_q;
	logic run_q;
	logic select_q;
	tacc_pkg::tacc_mode_s mode_q;
	logic [COUNT_WIDTH-1:0] reload_q;
	logic [COUNT_WIDTH-1:0] count_q;
	logic [COUNT_WIDTH-1:0] count_d;
	logic [COUNT_WIDTH-1:0] cap_q [CHANNELS];
	logic [2*CHANNELS-1:0] edge_cfg_q;
	logic [`TACC_EV_WIDTH-1:0] irq_stat_q;
	logic [`TACC_EV_WIDTH-1:0] irq_mask_q;

	// event logic
	logic [CHANNELS-1:0] pin_now;
	logic [CHANNELS-1:0] pin_prev_q;
	logic [CHANNELS-1:0] cap_hit;
	tacc_pkg::tacc_event_s ev;
	logic compare_mode;
	logic capture_reload;
	logic capture_clear;
	logic [31:0] rd_value;

	// decoded register strobes and next values
	logic wr_ctl;
	logic wr_mod;
	logic wr_rld;
	logic wr_cnt;
	logic wr_edg;
	logic wr_msk;
	logic rd_stat;
	logic flag_d;
	logic [`TACC_EV_WIDTH-1:0] irq_stat_d;
	logic [`TACC_EV_WIDTH-1:0] irq_mask_d;

	assign pin_now = {capture_pin_two, capture_pin_one, capture_pin_zero};
	assign compare_mode = select_q;
	assign addr_take = hsel & hready & htrans[1];
	assign wr_cycle = (bus_q == tacc_pkg::TACC_BUS_WRITE);
	assign rd_cycle = (bus_q == tacc_pkg::TACC_BUS_RD_WAIT);

	// one strobe per register so every block sees the same decode
	assign wr_ctl = reg_hit(wr_cycle, idx_q, `TACC_IDX_CONTROL);
	assign wr_mod = reg_hit(wr_cycle, idx_q, `TACC_IDX_MODE);
	assign wr_rld = reg_hit(wr_cycle, idx_q, `TACC_IDX_RELOAD);
	assign wr_cnt = reg_hit(wr_cycle, idx_q, `TACC_IDX_COUNTER);
	assign wr_edg = reg_hit(wr_cycle, idx_q, `TACC_IDX_EDGE_CFG);
	assign wr_msk = reg_hit(wr_cycle, idx_q, `TACC_IDX_IRQ_MASK);
	assign rd_stat = reg_hit(rd_cycle, idx_q, `TACC_IDX_IRQ_STATUS);

	// AHB-Lite slave sequencing: writes take no wait state, reads take one
	always_comb begin
		bus_d = tacc_pkg::TACC_BUS_IDLE;
		case (bus_q)
			tacc_pkg::TACC_BUS_RD_WAIT: begin
				bus_d = tacc_pkg::TACC_BUS_RD_DONE;
			end
			tacc_pkg::TACC_BUS_IDLE, tacc_pkg::TACC_BUS_WRITE, tacc_pkg::TACC_BUS_RD_DONE: begin
				if (addr_take) begin
					bus_d = hwrite ? tacc_pkg::TACC_BUS_WRITE : tacc_pkg::TACC_BUS_RD_WAIT;
				end
			end
			default: bus_d = tacc_pkg::TACC_BUS_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			bus_q <= tacc_pkg::TACC_BUS_IDLE;
			idx_q <= 8'h00;
		end else begin
			bus_q <= bus_d;
			if (addr_take && bus_q != tacc_pkg::TACC_BUS_RD_WAIT) begin
				idx_q <= reg_index(haddr);
			end
		end
	end

	// a read waits one cycle so that a write in the preceding data phase is visible
	assign hreadyout = (bus_q != tacc_pkg::TACC_BUS_RD_WAIT);
	assign hresp = 1'b0;

	// read multiplexer; reserved bits and unmapped words read zero
	always_comb begin
		rd_value = 32'h0000_0000;
		case (idx_q)
			`TACC_IDX_CONTROL: begin
				rd_value[`TACC_CTL_FLAG] = flag_q;
				rd_value[`TACC_CTL_RUN] = run_q;
				rd_value[`TACC_CTL_SELECT] = select_q;
			end
			`TACC_IDX_MODE: rd_value[7:2] = mode_q;
			`TACC_IDX_RELOAD: rd_value[COUNT_WIDTH-1:0] = reload_q;
			`TACC_IDX_COUNTER: rd_value[COUNT_WIDTH-1:0] = count_q;
			`TACC_IDX_CAPTURE0: rd_value[COUNT_WIDTH-1:0] = cap_q[0];
			`TACC_IDX_CAPTURE1: rd_value[COUNT_WIDTH-1:0] = cap_q[1];
			`TACC_IDX_CAPTURE2: rd_value[COUNT_WIDTH-1:0] = cap_q[2];
			`TACC_IDX_EDGE_CFG: rd_value[2*CHANNELS-1:0] = edge_cfg_q;
			`TACC_IDX_IRQ_STATUS: rd_value[`TACC_EV_WIDTH-1:0] = irq_stat_q;
			`TACC_IDX_IRQ_MASK: rd_value[`TACC_EV_WIDTH-1:0] = irq_mask_q;
			default: rd_value = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_cycle) begin
			hrdata <= rd_value;
		end
	end

	// capture pins: previous sample for edge detection
	// reset loads the live level, so a pin idling high gives no false edge after reset
	always_ff @(posedge clk) begin
		if (reset) begin
			pin_prev_q <= pin_now;
		end else begin
			pin_prev_q <= pin_now;
		end
	end

	// per-channel edge qualify and capture register
	for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
		assign cap_hit[c] = mode_q.capture_enable[c] &
			edge_hit(edge_cfg_q[2*c +: 2], pin_prev_q[c], pin_now[c]);
		always_ff @(posedge clk) begin
			if (reset) begin
				cap_q[c] <= '0;
			end else if (cap_hit[c]) begin
				cap_q[c] <= count_q;
			end
		end
	end

	// hardware events
	assign ev.capture = cap_hit;
	// overflow is flagged on the last count before the wrap, one cycle ahead of the new value
	assign ev.overflow = run_q & (count_q == {COUNT_WIDTH{1'b1}});
	assign ev.match = run_q & compare_mode & (count_q == reload_q);
	// capture actions do not need run control: a stopped counter can still be sampled
	assign capture_reload = (|cap_hit) & mode_q.reload_enable & ~select_q;
	assign capture_clear = (|cap_hit) & ~compare_mode & mode_q.capture_auto_clear;

	// counter next value; a software write beats every hardware action
	always_comb begin
		count_d = count_q;
		if (wr_cnt) begin
			count_d = hwdata[COUNT_WIDTH-1:0];
		end else if (capture_reload) begin
			count_d = reload_q;
		end else if (capture_clear) begin
			count_d = '0;
		end else if (run_q) begin
			if (ev.match && mode_q.compare_auto_clear) begin
				count_d = '0;
			end else if (ev.overflow && !compare_mode && mode_q.reload_enable) begin
				count_d = reload_q;
			end else begin
				count_d = count_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end

	// overflow/match flag: software may clear or set, hardware only sets; set wins
	always_comb begin
		flag_d = flag_q;
		if (wr_ctl) begin
			flag_d = hwdata[`TACC_CTL_FLAG];
		end
		// a hardware event in the same cycle as a software clear must not be lost
		if (ev.overflow || ev.match) begin
			flag_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			flag_q <= CTL_RESET[`TACC_CTL_FLAG];
		end else begin
			flag_q <= flag_d;
		end
	end

	// control and mode registers; reserved bits are not stored
	// select one picks compare mode, zero picks reload and capture mode
	always_ff @(posedge clk) begin
		if (reset) begin
			run_q <= CTL_RESET[`TACC_CTL_RUN];
			select_q <= CTL_RESET[`TACC_CTL_SELECT];
			mode_q <= MOD_RESET[7:2];
		end else begin
			if (wr_ctl) begin
				run_q <= hwdata[`TACC_CTL_RUN];
				select_q <= hwdata[`TACC_CTL_SELECT];
			end
			if (wr_mod) begin
				mode_q <= hwdata[7:2];
			end
		end
	end

	// reload value, edge config and interrupt mask
	always_ff @(posedge clk) begin
		if (reset) begin
			reload_q <= `TACC_RELOAD_RESET;
			edge_cfg_q <= `TACC_EDGE_RESET;
			irq_mask_q <= '0;
		end else begin
			if (wr_rld) begin
				reload_q <= hwdata[COUNT_WIDTH-1:0];
			end
			if (wr_edg) begin
				edge_cfg_q <= hwdata[2*CHANNELS-1:0];
			end
			irq_mask_q <= irq_mask_d;
		end
	end

	// sticky interrupt status, cleared by reading it; a new event in the
	// clearing cycle survives so that it is never lost
	always_comb begin
		irq_stat_d = irq_stat_q | ev;
		if (rd_stat) begin
			irq_stat_d = ev;
		end
		irq_mask_d = irq_mask_q;
		if (wr_msk) begin
			irq_mask_d = hwdata[`TACC_EV_WIDTH-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			irq_stat_q <= '0;
		end else begin
			irq_stat_q <= irq_stat_d;
		end
	end

	// irq follows the next status and mask, so it drops together with the clearing read
	always_ff @(posedge clk) begin
		if (reset) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_d & irq_mask_d);
		end
	end

	// hsize is not checked: only whole-word transfers are supported
	logic unused_ok;
	assign unused_ok = &{1'b0, hsize};

endmodule

// ### hdl/tacc_cfg.svh
// register indices, field positions, reset values and event bits of the aux timer block
// assumes a 32-bit word bus where byte address = 4 * register index
`ifndef TACC_CFG_SVH
`define TACC_CFG_SVH

// register indices; byte address is four times the index
`define TACC_IDX_CONTROL 8'hc8
`define TACC_IDX_MODE 8'hc9
`define TACC_IDX_RELOAD 8'hca
`define TACC_IDX_COUNTER 8'hcc
`define TACC_IDX_CAPTURE0 8'hd0
`define TACC_IDX_CAPTURE1 8'hd1
`define TACC_IDX_CAPTURE2 8'hd2
`define TACC_IDX_EDGE_CFG 8'hd3
`define TACC_IDX_IRQ_STATUS 8'hd4
`define TACC_IDX_IRQ_MASK 8'hd5

// control register fields
`define TACC_CTL_FLAG 7
`define TACC_CTL_RUN 2
`define TACC_CTL_SELECT 0
`define TACC_CTL_MASK 8'h85

// mode control register fields
`define TACC_MOD_RELOAD_EN 7
`define TACC_MOD_CAP_EN_LO 4
`define TACC_MOD_CAP_CLEAR 3
`define TACC_MOD_CMP_CLEAR 2
`define TACC_MOD_MASK 8'hfc

// reset values
`define TACC_CTL_RESET 8'h00
`define TACC_MOD_RESET 8'h00
`define TACC_EDGE_RESET 6'h00
`define TACC_RELOAD_RESET 16'h0000

// edge-select codes, two bits per channel
`define TACC_EDGE_FALL 2'b00
`define TACC_EDGE_RISE 2'b01
`define TACC_EDGE_BOTH 2'b10

// interrupt event bits
`define TACC_EV_OVERFLOW 0
`define TACC_EV_MATCH 1
`define TACC_EV_CAP_LO 2
`define TACC_EV_WIDTH 5

`endif

// ### hdl/tacc_pkg.sv
// types shared by the aux timer block
// assumes tacc_cfg.svh supplies the numeric constants
package tacc_pkg;

	// bus slave sequencing, one-hot
	typedef enum logic [3:0] {
		TACC_BUS_IDLE = 4'b0001,
		TACC_BUS_WRITE = 4'b0010,
		TACC_BUS_RD_WAIT = 4'b0100,
		TACC_BUS_RD_DONE = 4'b1000
	} tacc_bus_e;

	// mode control register as fields
	typedef struct packed {
		logic reload_enable;
		logic [2:0] capture_enable;
		logic capture_auto_clear;
		logic compare_auto_clear;
	} tacc_mode_s;

	// hardware events of one cycle
	typedef struct packed {
		logic [2:0] capture;
		logic match;
		logic overflow;
	} tacc_event_s;

endpackage

// ### sim/tacc_pin_model.sv
// far-side model of the three capture pins
// assumes the bench changes want right after a rising clk edge
`timescale 1ns/1ps
module tacc_pin_model (
	input wire logic clk,
	input wire logic [2:0] want,
	output logic capture_pin_zero,
	output logic capture_pin_one,
	output logic capture_pin_two
);
	// pins are synchronous to clk, so levels only move right after an edge
	always_ff @(posedge clk) begin
		{capture_pin_two, capture_pin_one, capture_pin_zero} <= want;
	end
endmodule

// ### sim/tacc_timer_properties.sv
// checker of the aux timer bus answer and interrupt ports
// assumes one clock domain; bound to every tacc_timer instance
`timescale 1ns/1ps
module tacc_timer_properties (
	input wire logic clk,
	input wire logic reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic irq
);
	logic rd_q;
	wire logic take = hsel && hready && htrans[1];
	always_ff @(posedge clk) begin
		rd_q <= !reset && take && !hwrite;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	okay_resp_a: assert property (!hresp) else $error("response not okay");
	read_wait_a: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait not one cycle");
	write_ready_a: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
	idle_ready_a: assert property (!rd_q |-> hreadyout) else $error("stray wait state");
	single_wait_a: assert property (!hreadyout |=> hreadyout) else $error("long wait");
	// hrdata may only move at the edge that ends a read wait
	data_hold_a: assert property (!$past(reset) && $past(hreadyout) |-> $stable(hrdata))
		else $error("read data moved");
	reset_quiet_a: assert property ($past(reset) |-> hreadyout && !irq && hrdata == '0)
		else $error("outputs busy after reset");
	unmapped_zero_a: assert property (take && !hwrite && haddr[31:10] != '0 |=> ##1 hrdata == '0)
		else $error("unmapped read not zero");
	cover property (rd_q);
	cover property ($rose(irq));
	cover property (take && hwrite);
endmodule
bind tacc_timer tacc_timer_properties i_props (.clk, .reset, .hsel, .haddr, .htrans, .hwrite,
	.hready, .hreadyout, .hresp, .hrdata, .irq);

// ### sim/tb_tacc_timer.sv
// self-checking bench of the aux timer through its bus and capture pins
// assumes the design, the pin model and the bound checker are compiled first
`timescale 1ns/1ps
`include "tacc_cfg.svh"
module tb_tacc_timer;
	localparam logic [7:0] CTL = `TACC_IDX_CONTROL, MD = `TACC_IDX_MODE;
	localparam logic [7:0] RLD = `TACC_IDX_RELOAD, CNT = `TACC_IDX_COUNTER, ST = `TACC_IDX_IRQ_STATUS;
	localparam logic [7:0] EDG = `TACC_IDX_EDGE_CFG, MSK = `TACC_IDX_IRQ_MASK;
	localparam logic [7:0] C0 = `TACC_IDX_CAPTURE0, C1 = `TACC_IDX_CAPTURE1, C2 = `TACC_IDX_CAPTURE2;
	logic clk = 1'b0, reset = 1'b1, hsel = 1'b0, hwrite = 1'b0, hready, hresp, irq, p0, p1, p2;
	logic [1:0] htrans = 2'b00;
	logic [2:0] want = 3'h0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
	int failures = 0, samples_checked = 0;
	tacc_timer i_dut (.clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready, .hreadyout(hready), .hresp, .hrdata,
		.capture_pin_zero(p0), .capture_pin_one(p1), .capture_pin_two(p2), .irq);
	tacc_pin_model i_pins (.clk, .want,
		.capture_pin_zero(p0), .capture_pin_one(p1), .capture_pin_two(p2));
	initial begin
		forever #2.5 clk = ~clk;
	end
	task automatic give_verdict();
		$display("checked %0d, failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic ok(input logic c);
		samples_checked++;
		if (c !== 1'b1) begin
			failures++;
			$display("[FAIL] %0t mismatch, last read %h", $time, rd);
		end
	endtask
	// read just after a rising edge, hready and hrdata still hold the values sampled there
	task automatic hwait();
		int n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 40);
		rd = hrdata;
		if (hready !== 1'b1) begin
			failures++;
			$display("[FAIL] %0t bus answer missing", $time);
			give_verdict();
		end
	endtask
	task automatic xfer(input logic w, input logic [31:0] a, input logic [15:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'b10;
		hwrite <= w;
		hwait();
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {16'h0000, d};
		hwait();
	endtask
	task automatic wr(input logic [7:0] i, input logic [15:0] d);
		xfer(1'b1, {22'h00_0000, i, 2'b00}, d);
	endtask
	task automatic rdr(input logic [7:0] i);
		xfer(1'b0, {22'h00_0000, i, 2'b00}, 16'h0000);
	endtask
	task automatic chk(input logic [7:0] i, input logic [15:0] e);
		rdr(i);
		ok(rd === {16'h0000, e});
	endtask
	// four edges: model register, then capture, status and irq together at the next edge, two spare
	task automatic pins(input logic [2:0] v);
		want <= v;
		repeat (4) @(posedge clk);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		chk(CTL, 16'h0000);
		chk(MD, 16'h0000);
		xfer(1'b0, 32'h0000_0400, 16'h0000);
		ok(rd === 32'h0000_0000);
		wr(MD, 16'hffff);
		chk(MD, 16'h00fc);
		wr(MD, 16'h0000);
		wr(CTL, 16'hffff);
		chk(CTL, 16'h0085);
		wr(CTL, 16'h0000);
		chk(CTL, 16'h0000);
		wr(CTL, 16'h0080);
		chk(CTL, 16'h0080);
		wr(CNT, 16'hfff0);
		rdr(ST);
		wr(CTL, 16'h0004);
		repeat (30) @(posedge clk);
		chk(CTL, 16'h0084);
		chk(ST, 16'h0001);
		wr(CTL, 16'h0080);
		wr(CNT, 16'h1234);
		repeat (10) @(posedge clk);
		chk(CNT, 16'h1234);
		chk(CTL, 16'h0080);
		wr(RLD, 16'h0020);
		wr(MD, 16'h0004);
		wr(CNT, 16'h0000);
		wr(CTL, 16'h0005);
		repeat (100) @(posedge clk);
		chk(CTL, 16'h0085);
		wr(CTL, 16'h0001);
		rdr(CNT);
		ok(rd <= 32'h0000_0020);
		wr(MD, 16'h0000);
		wr(CTL, 16'h0005);
		repeat (100) @(posedge clk);
		wr(CTL, 16'h0001);
		rdr(CNT);
		ok(rd > 32'h0000_0020);
		wr(CTL, 16'h0000);
		wr(EDG, 16'h0024);
		wr(MSK, 16'h001c);
		wr(MD, 16'h0070);
		wr(CNT, 16'h0abc);
		rdr(ST);
		pins(3'b111);
		ok(irq === 1'b1);
		chk(C0, 16'h0000);
		chk(C1, 16'h0abc);
		chk(C2, 16'h0abc);
		chk(ST, 16'h0018);
		@(posedge clk);
		ok(irq === 1'b0);
		wr(CNT, 16'h0555);
		pins(3'b000);
		chk(C0, 16'h0555);
		chk(C1, 16'h0abc);
		chk(C2, 16'h0555);
		wr(EDG, 16'h003e);
		wr(MSK, 16'h0000);
		rdr(ST);
		pins(3'b111);
		ok(irq === 1'b0);
		chk(ST, 16'h0004);
		wr(EDG, 16'h0024);
		wr(MD, 16'h0078);
		wr(CNT, 16'h0100);
		pins(3'b110);
		chk(CNT, 16'h0000);
		chk(C0, 16'h0100);
		wr(MD, 16'h00f0);
		wr(RLD, 16'h0077);
		wr(CNT, 16'h0100);
		pins(3'b010);
		chk(CNT, 16'h0077);
		wr(CTL, 16'h0001);
		wr(CNT, 16'h0100);
		pins(3'b110);
		chk(CNT, 16'h0100);
		wr(CTL, 16'h0000);
		wr(MD, 16'h0070);
		pins(3'b010);
		chk(CNT, 16'h0100);
		wr(MD, 16'h0080);
		wr(RLD, 16'h8000);
		wr(CNT, 16'hfff0);
		wr(CTL, 16'h0004);
		repeat (30) @(posedge clk);
		wr(CTL, 16'h0000);
		rdr(CNT);
		ok(rd[15:0] > 16'h8000 && rd[15:0] < 16'h8040);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		chk(CNT, 16'h0000);
		chk(RLD, 16'h0000);
		chk(MD, 16'h0000);
		give_verdict();
	end
endmodule
